// ==== core/dde_divider.sv ====
/*
  restoring divider, eight bits unsigned, four quotient bits per cycle.
  assumes a start pulse with stable operands for that cycle only.
*/
`include "dde_map.svh"
module dde_divider #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] dividend,
  input  wire logic [WIDTH-1:0] divisor,
  output logic      [WIDTH-1:0] quotient,
  output logic      [WIDTH-1:0] remainder,
  output logic                  done
);
  import dde_pkg::*;
  if (WIDTH != 8) begin : g_width_check
    $error("divider serves eight bits only");
  end
  logic [WIDTH-1:0] dsor;
  logic [1:0]       step;
  logic             busy;
  // four restoring steps per clock; two working edges leave the caller's
  // result stage inside the four-cycle budget
  function automatic logic [2*WIDTH-1:0] div_step(
    input logic [2*WIDTH-1:0] rq, input logic [WIDTH-1:0] d);
    logic [WIDTH:0] trial;
    logic [2*WIDTH-1:0] sh;
    sh    = {rq[2*WIDTH-2:0], 1'b0};
    trial = {1'b0, sh[2*WIDTH-1:WIDTH]} - {1'b0, d};
    if (!trial[WIDTH]) begin
      sh[2*WIDTH-1:WIDTH] = trial[WIDTH-1:0];
      sh[0] = 1'b1;
    end
    return sh;
  endfunction : div_step
  logic [2*WIDTH-1:0] rq;
  wire  [2*WIDTH-1:0] half_rq = div_step(div_step(rq, dsor), dsor);
  wire  [2*WIDTH-1:0] next_rq = div_step(div_step(half_rq, dsor), dsor);
  assign quotient  = rq[WIDTH-1:0];
  assign remainder = rq[2*WIDTH-1:WIDTH];
  // sequencer; a zero divisor simply runs and yields an undefined pair
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rq   <= '0;
      dsor <= '0;
      step <= 2'h0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        rq   <= {{WIDTH{1'b0}}, dividend};
        dsor <= divisor;
        step <= 2'h0;
        busy <= 1'b1;
      end else if (busy) begin
        rq   <= next_rq;
        step <= step + 2'h1;
        if (step == 2'h1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule : dde_divider

// ==== core/dde_exec.sv ====
/*
  execution datapath for the decrement family and the unsigned divide.
  assumes the decoder presents one instruction per issue pulse with its
  operand values already fetched; port targets supply the output latch.
*/
// Summary of operation
// [RL1] accumulator decrement stores accumulator minus one
// [RL2] 00011rrr decrements working register, one cycle
// [RL3] 00010101 plus address decrements direct byte
// [RL4] divide: quotient to acc, remainder aux, four cycles
// [RL5] nonzero divisor divide clears carry and overflow
// [RL6] zero divisor leaves quotient and remainder undefined
// [RL7] zero divisor sets overflow; carry always cleared
// [RL8] decrements wrap zero to all ones, flags untouched
// [RL9] port decrement reads output latch, not pins
// [RL10] 0001011i decrements ram byte via pointer register
`include "dde_map.svh"
module dde_exec #(
  parameter logic [7:0] DIV_OPCODE = `DDE_OP_DIV_DEFAULT
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              issue,
  input  wire logic [7:0]        opcode,
  input  wire logic [7:0]        direct_addr,
  input  wire logic [7:0]        acc_in,
  input  wire logic [7:0]        aux_in,
  input  wire logic [7:0]        working_register_in,
  input  wire logic [7:0]        pointer_register_0,
  input  wire logic [7:0]        pointer_register_1,
  input  wire logic [7:0]        mem_in,
  input  wire logic              dir_is_port,
  input  wire logic [7:0]        port_latch_in,
  input  wire logic              carry_in,
  input  wire logic              overflow_flag_in,
  output logic                   busy,
  output logic                   done,
  output dde_pkg::dde_kind_t     kind,
  output logic      [2:0]        reg_sel,
  output logic      [7:0]        wr_addr,
  output logic      [7:0]        result,
  output logic      [7:0]        acc_out,
  output logic      [7:0]        aux_out,
  output logic                   acc_we,
  output logic                   aux_we,
  output logic                   carry_out,
  output logic                   overflow_flag_out,
  output logic                   illegal
);
  import dde_pkg::*;
  // refuse a divide opcode that would shadow a decrement form
  if (DIV_OPCODE[7:3] == `DDE_OP_DEC_REG_HI ||
      DIV_OPCODE[7:1] == `DDE_OP_DEC_IND_HI ||
      DIV_OPCODE == `DDE_OP_DEC_ACC ||
      DIV_OPCODE == `DDE_OP_DEC_DIR) begin : g_opcode_check
    $error("divide opcode collides with a decrement opcode");
  end

  // shared by every decrement form; eight-bit arithmetic wraps 00 to FF
  function automatic logic [7:0] dec8(input logic [7:0] v);
    return v - `DDE_ONE;
  endfunction : dec8

  // opcode decode
  wire is_acc = opcode == `DDE_OP_DEC_ACC;             // [RL1]
  wire is_reg = opcode[7:3] == `DDE_OP_DEC_REG_HI;     // [RL2]
  wire is_dir = opcode == `DDE_OP_DEC_DIR;             // [RL3]
  wire is_ind = opcode[7:1] == `DDE_OP_DEC_IND_HI;     // [RL10]
  wire is_div = opcode == DIV_OPCODE;                  // [RL4]
  wire [7:0] ind_addr = opcode[0] ? pointer_register_1
                                  : pointer_register_0; // [RL10]
  // direct port targets read the output latch so pin loading is ignored
  wire [7:0] dir_src = dir_is_port ? port_latch_in : mem_in; // [RL9]
  wire [7:0] dec_src = is_acc ? acc_in :
                       is_reg ? working_register_in :
                       is_dir ? dir_src : mem_in;
  wire [7:0] dec_val = dec8(dec_src);                  // [RL8]
  wire is_dec  = is_acc | is_reg | is_dir | is_ind;
  wire div_go  = issue && !busy && is_div;
  wire dec_go  = issue && !busy && is_dec;
  wire div_zero;

  dde_state_t state;
  logic [7:0] q;
  logic [7:0] r;
  logic       div_done;
  logic       zero_seen;

  dde_divider #(.WIDTH(8)) u_div (
    .core_clk (core_clk),
    .rst_b    (rst_b),
    .start    (div_go),
    .dividend (acc_in),
    .divisor  (aux_in),
    .quotient (q),
    .remainder(r),
    .done     (div_done)
  );
  assign div_zero = aux_in == `DDE_ZERO;
  assign busy = state == DDE_DIV_RUN;

  // divide sequencer; issue is ignored while the divider runs
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state     <= DDE_IDLE;
      zero_seen <= 1'b0;
    end else begin
      unique case (state)
        DDE_IDLE: begin
          if (div_go) begin
            state     <= DDE_DIV_RUN;
            zero_seen <= div_zero;
          end
        end
        DDE_DIV_RUN: begin
          if (div_done) state <= DDE_IDLE;
        end
        default: state <= DDE_IDLE;
      endcase
    end
  end

  // result registers, updated for one cycle per completed instruction
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      done              <= 1'b0;
      kind              <= DDE_K_NONE;
      reg_sel           <= 3'h0;
      wr_addr           <= 8'h00;
      result            <= 8'h00;
      acc_out           <= 8'h00;
      aux_out           <= 8'h00;
      acc_we            <= 1'b0;
      aux_we            <= 1'b0;
      carry_out         <= 1'b0;
      overflow_flag_out <= 1'b0;
      illegal           <= 1'b0;
    end else begin
      done    <= 1'b0;
      acc_we  <= 1'b0;
      aux_we  <= 1'b0;
      illegal <= issue && !busy && !is_dec && !is_div;
      if (dec_go) begin
        done    <= 1'b1;                               // [RL2] [RL3]
        result  <= dec_val;
        reg_sel <= opcode[2:0];
        wr_addr <= is_ind ? ind_addr : direct_addr;
        acc_we  <= is_acc;                             // [RL1]
        acc_out <= is_acc ? dec_val : acc_out;
        kind    <= is_acc ? DDE_K_ACC : is_reg ? DDE_K_REG :
                   is_dir ? DDE_K_DIR : DDE_K_IND;
        // flags pass through unchanged
        carry_out         <= carry_in;                 // [RL8]
        overflow_flag_out <= overflow_flag_in;         // [RL8]
      end else if (div_done) begin
        done              <= 1'b1;                     // [RL4]
        kind              <= DDE_K_DIV;
        acc_out           <= q;                        // [RL4] [RL6]
        aux_out           <= r;
        acc_we            <= 1'b1;
        aux_we            <= 1'b1;
        carry_out         <= 1'b0;                     // [RL5] [RL7]
        overflow_flag_out <= zero_seen;                // [RL5] [RL7]
      end
    end
  end

  // all checks run on the core clock and stay quiet while reset is low
  default clocking dde_cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_b);

  // divide done arrives four cycles after the accepted issue
  chk_div_latency: assert property ( // [RL4]
    div_go |-> ##4 (done && kind == DDE_K_DIV))
    else $error("divide did not finish in four cycles");
  chk_div_values: assert property ( // [RL4]
    (div_go && !div_zero) |-> ##4 (acc_out == $past(acc_in, 4) /
      $past(aux_in, 4) && aux_out == $past(acc_in, 4) % $past(aux_in, 4)))
    else $error("divide quotient or remainder wrong");
  chk_div_flags_ok: assert property ( // [RL5]
    (div_go && !div_zero) |-> ##4 (!carry_out && !overflow_flag_out))
    else $error("flags not cleared after divide");
  chk_div_by_zero: assert property ( // [RL7]
    (div_go && div_zero) |-> ##4 (overflow_flag_out && !carry_out))
    else $error("zero divisor flags wrong");
  // a swallowed issue must not finish anything while the divider runs
  chk_busy_quiet: assert property ( // [RL4]
    (busy && !div_done) |=> !done)
    else $error("instruction finished while divide was running");
  chk_div_we: assert property ( // [RL4]
    div_done |=> (acc_we && aux_we))
    else $error("divide did not write both registers");
  // every decrement form finishes on the edge after it is taken
  chk_dec_latency: assert property ( // [RL2] [RL3]
    dec_go |=> (done && kind != DDE_K_DIV && kind != DDE_K_NONE))
    else $error("decrement did not finish in one cycle");
  chk_acc_dec: assert property ( // [RL1]
    (dec_go && is_acc) |=> (acc_we && acc_out == $past(acc_in) - 8'h01))
    else $error("accumulator decrement wrong");
  chk_reg_dec: assert property ( // [RL2]
    (dec_go && is_reg) |=> (done && kind == DDE_K_REG &&
      reg_sel == $past(opcode[2:0]) &&
      result == $past(working_register_in) - 8'h01))
    else $error("working register decrement wrong");
  chk_dir_port: assert property ( // [RL3] [RL9]
    (dec_go && is_dir && dir_is_port) |=>
      (result == $past(port_latch_in) - 8'h01 &&
       wr_addr == $past(direct_addr)))
    else $error("port decrement not from latch");
  chk_dec_flags: assert property ( // [RL8]
    dec_go |=> (carry_out == $past(carry_in) &&
      overflow_flag_out == $past(overflow_flag_in)))
    else $error("decrement changed a flag");
  chk_ind_addr: assert property ( // [RL10]
    (dec_go && is_ind) |=> (wr_addr == ($past(opcode[0]) ?
      $past(pointer_register_1) : $past(pointer_register_0))))
    else $error("indirect address wrong");
  // main scenarios worth seeing at least once
  cov_div_zero: cover property (div_go && div_zero);
  cov_div_ok: cover property (div_go && !div_zero);
  cov_wrap: cover property (dec_go && dec_src == 8'h00);
  cov_ind1: cover property (dec_go && is_ind && opcode[0]);
  cov_port: cover property (dec_go && is_dir && dir_is_port);
endmodule : dde_exec

// ==== core/dde_map.svh ====
/*
  constants of the decrement and divide execution datapath: opcode
  patterns, cycle counts and the one and zero byte constants.
  assumes inclusion by bare name from the design files.
*/
`ifndef DDE_MAP_SVH
`define DDE_MAP_SVH
`define DDE_OP_DEC_ACC     8'h14
`define DDE_OP_DEC_DIR     8'h15
`define DDE_OP_DEC_IND_HI  7'h0B
`define DDE_OP_DEC_REG_HI  5'h03
`define DDE_OP_DIV_DEFAULT 8'h84
`define DDE_DIV_CYCLES     4
`define DDE_DEC_CYCLES     1
`define DDE_ONE            8'h01
`define DDE_ZERO           8'h00
`endif

// ==== core/dde_pkg.sv ====
/*
  types shared by the datapath files.
  assumes nothing beyond a systemverilog compiler.
*/
package dde_pkg;
  typedef enum logic [2:0] {
    DDE_IDLE, DDE_DIV_RUN
  } dde_state_t;
  typedef enum logic [2:0] {
    DDE_K_NONE, DDE_K_ACC, DDE_K_REG, DDE_K_DIR, DDE_K_IND, DDE_K_DIV
  } dde_kind_t;
endpackage : dde_pkg

// ==== verification/tb_top.sv ====
/*
  self-checking bench for the decrement and divide execution datapath.
  assumes dde_exec with its default divide opcode, one 125 MHz clock and
  operand values presented by the bench with each issue.
*/
module tb_top import dde_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic       core_clk = 1'b0, rst_b = 1'b0, issue = 1'b0;
  logic [7:0] opcode = 8'h00, direct_addr = 8'h00, acc_in = 8'h00;
  logic [7:0] aux_in = 8'h00, working_register_in = 8'h00, mem_in = 8'h00;
  logic [7:0] pointer_register_0 = 8'h7E, pointer_register_1 = 8'h7F;
  logic       dir_is_port = 1'b0, carry_in = 1'b0, overflow_flag_in = 1'b0;
  logic [7:0] port_latch_in = 8'h00;
  logic       busy, done, acc_we, aux_we, carry_out, overflow_flag_out;
  logic       illegal;
  dde_kind_t  kind;
  logic [2:0] reg_sel;
  logic [7:0] wr_addr, result, acc_out, aux_out;
  int         n_fail = 0, checks = 0, n;

  dde_exec dde_exec_inst (.core_clk(core_clk), .rst_b(rst_b), .issue(issue),
    .opcode(opcode), .direct_addr(direct_addr), .acc_in(acc_in),
    .aux_in(aux_in), .working_register_in(working_register_in),
    .pointer_register_0(pointer_register_0),
    .pointer_register_1(pointer_register_1), .mem_in(mem_in),
    .dir_is_port(dir_is_port), .port_latch_in(port_latch_in),
    .carry_in(carry_in), .overflow_flag_in(overflow_flag_in), .busy(busy),
    .done(done), .kind(kind), .reg_sel(reg_sel), .wr_addr(wr_addr),
    .result(result), .acc_out(acc_out), .aux_out(aux_out), .acc_we(acc_we),
    .aux_we(aux_we), .carry_out(carry_out),
    .overflow_flag_out(overflow_flag_out), .illegal(illegal));

  // 8 ns period
  always #4 core_clk = ~core_clk;

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // issue one op just after a rising edge; spam re-issues a decrement once,
  // which busy must swallow; b is busy in the cycle after the issue
  task automatic run(input logic [7:0] op, input bit spam, output int c,
                     output logic b);
    issue  <= 1'b1;
    opcode <= op;
    @(posedge core_clk);
    issue  <= spam;
    opcode <= spam ? 8'h14 : op;
    c = 1;
    @(negedge core_clk);
    b = busy;
    while (done !== 1'b1 && c < 8) begin
      @(posedge core_clk);
      issue <= 1'b0;
      @(negedge core_clk);
      c++;
    end
  endtask : run

  task automatic t_acc;
    logic b;
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      acc_in           <= i ? 8'h80 : 8'h00;
      carry_in         <= ~i[0];
      overflow_flag_in <= i[0];
      run(8'h14, 1'b0, n, b);
      chk("dec cycles", 8'h01, 8'(n));
      chk("dec busy", 8'h00, {7'h00, b});
      chk("acc kind", 8'(DDE_K_ACC), {5'h00, kind});
      chk("acc_out", i ? 8'h7F : 8'hFF, acc_out);
      chk("acc_we", 8'h01, {7'h00, acc_we});
      chk("flags", {6'h00, ~i[0], i[0]},
          {6'h00, carry_out, overflow_flag_out});
    end
  endtask : t_acc

  // eight working registers issued back to back, one per cycle
  task automatic t_reg;
    for (int r = 0; r < 9; r++) begin
      @(posedge core_clk);
      issue               <= (r < 8);
      opcode              <= 8'h18 | 8'(r);
      working_register_in <= 8'(r * 17);
      @(negedge core_clk);
      if (r > 0) begin
        chk("reg done", 8'h01, {7'h00, done});
        chk("reg kind", 8'(DDE_K_REG), {5'h00, kind});
        chk("reg_sel", 8'(r - 1), {5'h00, reg_sel});
        chk("reg result", 8'((r - 1) * 17 - 1), result);
      end
    end
  endtask : t_reg

  task automatic t_dir;
    logic b;
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      direct_addr   <= i ? 8'h30 : 8'h90;
      dir_is_port   <= ~i[0];
      port_latch_in <= 8'h40;
      mem_in        <= i ? 8'h00 : 8'h99;
      run(8'h15, 1'b0, n, b);
      chk("dir cycles", 8'h01, 8'(n));
      chk("dir kind", 8'(DDE_K_DIR), {5'h00, kind});
      chk("dir addr", i ? 8'h30 : 8'h90, wr_addr);
      chk("dir result", i ? 8'hFF : 8'h3F, result);
    end
  endtask : t_dir

  task automatic t_ind;
    logic b;
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      mem_in <= i ? 8'h40 : 8'h00;
      run(8'h16 | 8'(i), 1'b0, n, b);
      chk("ind cycles", 8'h01, 8'(n));
      chk("ind kind", 8'(DDE_K_IND), {5'h00, kind});
      chk("ind addr", i ? 8'h7F : 8'h7E, wr_addr);
      chk("ind result", i ? 8'h3F : 8'hFF, result);
    end
  endtask : t_ind

  // dividend, divisor, quotient, remainder; last row divides by zero
  task automatic t_div;
    logic [7:0] tb [4][4] = '{'{8'hFB, 8'h12, 8'h0D, 8'h11},
      '{8'hFF, 8'h01, 8'hFF, 8'h00}, '{8'h07, 8'h09, 8'h00, 8'h07},
      '{8'h05, 8'h00, 8'h00, 8'h00}};
    logic       b;
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      acc_in           <= tb[i][0];
      aux_in           <= tb[i][1];
      carry_in         <= 1'b1;
      overflow_flag_in <= (i < 3);
      run(8'h84, (i == 0), n, b);
      chk("div cycles", 8'h04, 8'(n));
      chk("div busy", 8'h01, {7'h00, b});
      chk("busy at done", 8'h00, {7'h00, busy});
      chk("div kind", 8'(DDE_K_DIV), {5'h00, kind});
      chk("div we", 8'h03, {6'h00, acc_we, aux_we});
      chk("div carry", 8'h00, {7'h00, carry_out});
      chk("div ov", 8'(i == 3), {7'h00, overflow_flag_out});
      if (i < 3) begin
        chk("quotient", tb[i][2], acc_out);
        chk("remainder", tb[i][3], aux_out);
      end
      @(negedge core_clk);
      chk("no extra done", 8'h00, {7'h00, done});
    end
  endtask : t_div

  task automatic t_ill;
    @(posedge core_clk);
    issue  <= 1'b1;
    opcode <= 8'hA5;
    @(posedge core_clk);
    issue <= 1'b0;
    @(negedge core_clk);
    chk("illegal", 8'h01, {7'h00, illegal});
  endtask : t_ill

  task automatic report_and_stop;
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // the sequence needs well under a hundred cycles; allow ample margin
  initial begin
    #(8 * 5000);
    n_fail++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    t_acc();
    t_reg();
    t_dir();
    t_ind();
    t_div();
    t_ill();
    report_and_stop();
  end
endmodule : tb_top
